// file: verilog/uhe_host_ctrl.sv
// Purpose: host port and host endpoint pair control behind an axi4-lite register file
// Assumes: a packet engine on the same clock runs the usb wire protocol for us
// Notes:   one transaction at a time; a token write launches it
// Summary of operation
// [RULE1] port register bit 5 shows d+ level
// [RULE2] port register bit 4 shows d- level
// [RULE3] bit 2 picks low or full speed
// [RULE4] bit 1 forces bus reset until cleared
// [RULE5] bit 0 enables port; disconnect clears it
// [RULE6] setup and out only with transmit enabled
// [RULE7] transmit buffer single, or double by toggle
// [RULE8] receive buffer single, or double by toggle
// [RULE9] software gives aligned addresses; low 15 used
// [RULE10] preamble bit makes engine send pre pid
// [RULE11] sof bit enables automatic frame starts
// [RULE12] token register holds pid and endpoint
// [RULE13] in data checked against expected toggle
// [RULE14] receive auto flip after good reception
// [RULE15] in transactions answered with ack unless disabled
// [RULE16] software loads transmit length before launch
// [RULE17] outgoing data pid follows transmit toggle
// [RULE18] transmit auto flip after good transmission
// [RULE19] setup and out await ack unless disabled
// [RULE20] every transaction sets done and handshake pid
// [RULE21] receive count and toggle match recorded
// [RULE22] software drops data with toggle mismatch
// [RULE23] bit 7 disables pull-downs, resets set
// [RULE24] token write launches one transaction
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module uhe_host_ctrl #(
    parameter int unsigned FRAME_CYCLES = uhe_pkg::FRAME_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        dplus_line_level,
    input  wire logic        dminus_line_level,
    output logic             pulldown_enable,
    output logic             force_bus_reset,
    output logic             root_port_enable,
    output logic             port_slow_speed_select,
    output logic             preamble_enable,
    output logic             frame_start_request,
    output logic             xact_start,
    output logic [3:0]       xact_token_pid,
    output logic [3:0]       xact_endpoint,
    output logic [3:0]       xact_data_pid,
    output logic [14:0]      xact_buffer_address,
    output logic [7:0]       xact_length,
    output logic             xact_expect_handshake,
    output logic             xact_send_ack,
    input  wire logic        xact_done,
    input  wire logic [3:0]  xact_handshake_pid,
    input  wire logic [3:0]  xact_rx_data_pid,
    input  wire logic [7:0]  xact_rx_count
);
    typedef struct packed {
        logic        dp_s1, dp_s2, dm_s1, dm_s2;
        logic        pd_dis, slow, bus_rst, port_en;
        logic        tx_en, tx_dbl, rx_en, rx_dbl;
        logic [15:0] rx_addr, tx_addr;
        logic        pre, sof_en;
        logic [7:0]  token;
        logic        rx_tog, rx_auto, rx_nohs;
        logic [7:0]  tx_len;
        logic        tx_tog, tx_auto, tx_nohs;
        logic        done, tog_ok;
        logic [3:0]  hs_pid;
        logic [7:0]  rx_count;
        uhe_pkg::uhe_eng_type eng;
        logic        start, is_in, sof_pulse;
        logic [3:0]  data_pid;
        logic [14:0] buf_addr;
        logic [15:0] frame_cnt;
        logic [7:0]  se0_cnt;
        logic        bvalid, rvalid;
        logic [1:0]  bresp, rresp;
        logic [31:0] rdata;
    } uhe_state_type;

    uhe_state_type q;
    uhe_state_type next_q;

    function automatic logic token_is_in(input logic [7:0] tok);
        return tok[7:4] == uhe_pkg::PID_IN;
    endfunction

    function automatic logic [14:0] pick_buffer(input logic [15:0] base,
                                                input logic dbl, input logic tog);
        // upper address bit is ignored, alignment is software's duty
        return base[uhe_pkg::ADDR_BITS-1:0] + ((dbl && tog) ? uhe_pkg::BUF_STEP : 15'h0000); // RULE9
    endfunction

    logic       wr_go;
    logic       rd_go;
    logic [5:0] wr_idx;
    logic [5:0] rd_idx;
    logic [7:0] wb;
    logic       tx_ok;

    assign wr_go         = s_axi_awvalid && s_axi_wvalid && !q.bvalid;
    assign rd_go         = s_axi_arvalid && !q.rvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = rd_go;
    assign wr_idx        = s_axi_awaddr[7:2];
    assign rd_idx        = s_axi_araddr[7:2];
    assign wb            = s_axi_wdata[7:0];
    assign tx_ok         = q.tx_nohs || xact_handshake_pid == uhe_pkg::PID_ACK;

    always_comb
    begin
        next_q = q;
        next_q.start = 1'b0;
        next_q.sof_pulse = 1'b0;
        next_q.dp_s1 = dplus_line_level;
        next_q.dp_s2 = q.dp_s1;
        next_q.dm_s1 = dminus_line_level;
        next_q.dm_s2 = q.dm_s1;
        if (q.bvalid && s_axi_bready) next_q.bvalid = 1'b0;
        if (q.rvalid && s_axi_rready) next_q.rvalid = 1'b0;
        if (wr_go)
        begin
            next_q.bvalid = 1'b1;
            next_q.bresp = uhe_pkg::RESP_OKAY;
            case (wr_idx)
                uhe_pkg::IDX_PORT:
                if (s_axi_wstrb[0])
                begin
                    next_q.pd_dis  = wb[uhe_pkg::PORT_PD_DIS];
                    next_q.slow    = wb[uhe_pkg::PORT_SLOW];
                    next_q.bus_rst = wb[uhe_pkg::PORT_BUSRST];
                    next_q.port_en = wb[uhe_pkg::PORT_EN];
                end
                uhe_pkg::IDX_MODE:
                if (s_axi_wstrb[0])
                begin
                    next_q.tx_en  = wb[uhe_pkg::MODE_TX_EN];
                    next_q.tx_dbl = wb[uhe_pkg::MODE_TX_DBL];
                    next_q.rx_en  = wb[uhe_pkg::MODE_RX_EN];
                    next_q.rx_dbl = wb[uhe_pkg::MODE_RX_DBL];
                end
                uhe_pkg::IDX_RXADDR:
                begin
                    if (s_axi_wstrb[0]) next_q.rx_addr[7:0] = wb;
                    if (s_axi_wstrb[1]) next_q.rx_addr[15:8] = s_axi_wdata[15:8];
                end
                uhe_pkg::IDX_TXADDR:
                begin
                    if (s_axi_wstrb[0]) next_q.tx_addr[7:0] = wb;
                    if (s_axi_wstrb[1]) next_q.tx_addr[15:8] = s_axi_wdata[15:8];
                end
                uhe_pkg::IDX_AUX:
                if (s_axi_wstrb[0])
                begin
                    next_q.pre    = wb[uhe_pkg::AUX_PRE];
                    next_q.sof_en = wb[uhe_pkg::AUX_SOF];
                end
                uhe_pkg::IDX_TOKEN:
                // a rewrite while busy is dropped so the running transfer keeps its setup
                if (s_axi_wstrb[0] && q.eng == uhe_pkg::ENG_IDLE)
                begin
                    next_q.token = wb; // RULE12
                    next_q.is_in = token_is_in(wb);
                    if (q.port_en && (token_is_in(wb) ? q.rx_en : q.tx_en)) // RULE6
                    begin
                        next_q.start = 1'b1; // RULE24
                        next_q.eng = uhe_pkg::ENG_BUSY;
                        next_q.data_pid = q.tx_tog ? uhe_pkg::PID_DATA1 : uhe_pkg::PID_DATA0; // RULE17
                        next_q.buf_addr = token_is_in(wb)
                            ? pick_buffer(q.rx_addr, q.rx_dbl, q.rx_tog)  // RULE8
                            : pick_buffer(q.tx_addr, q.tx_dbl, q.tx_tog); // RULE7
                    end
                    else
                    begin
                        next_q.done = 1'b1;
                        next_q.hs_pid = uhe_pkg::PID_NONE;
                    end
                end
                uhe_pkg::IDX_RXCTRL:
                if (s_axi_wstrb[0])
                begin
                    next_q.rx_tog  = wb[uhe_pkg::CTRL_RTOG];
                    next_q.rx_auto = wb[uhe_pkg::CTRL_AUTO];
                    next_q.rx_nohs = wb[uhe_pkg::CTRL_RNOHS];
                end
                uhe_pkg::IDX_TXLEN:
                if (s_axi_wstrb[0])
                begin
                    next_q.tx_len = wb;
                end
                uhe_pkg::IDX_TXCTRL:
                if (s_axi_wstrb[0])
                begin
                    next_q.tx_tog  = wb[uhe_pkg::CTRL_TTOG];
                    next_q.tx_auto = wb[uhe_pkg::CTRL_AUTO];
                    next_q.tx_nohs = wb[uhe_pkg::CTRL_TNOHS];
                end
                uhe_pkg::IDX_STATUS:
                if (s_axi_wstrb[0] && wb[uhe_pkg::STAT_DONE])
                begin
                    next_q.done = 1'b0;
                end
                // receive count is read-only: the write is accepted and dropped
                uhe_pkg::IDX_RXCNT: next_q.bresp = uhe_pkg::RESP_OKAY;
                default:            next_q.bresp = uhe_pkg::RESP_SLV;
            endcase
        end
        // completion comes after software writes so a hardware set wins
        if (xact_done && q.eng == uhe_pkg::ENG_BUSY)
        begin
            next_q.eng = uhe_pkg::ENG_IDLE;
            next_q.done = 1'b1; // RULE20
            next_q.hs_pid = xact_handshake_pid;
            if (q.is_in)
            begin
                next_q.rx_count = xact_rx_count; // RULE21
                next_q.tog_ok = xact_rx_data_pid ==
                    (q.rx_tog ? uhe_pkg::PID_DATA1 : uhe_pkg::PID_DATA0); // RULE13
                if (next_q.tog_ok && q.rx_auto)
                begin
                    next_q.rx_tog = !q.rx_tog; // RULE14
                end
            end
            else if (tx_ok && q.tx_auto)
            begin
                next_q.tx_tog = !q.tx_tog; // RULE18
            end
        end
        // disconnect: both lines low long enough outside a forced reset
        if (q.port_en && !q.bus_rst && !q.dp_s2 && !q.dm_s2)
        begin
            next_q.se0_cnt = q.se0_cnt + 8'h01;
            if (q.se0_cnt == 8'(uhe_pkg::DISC_CYC - 1))
            begin
                next_q.port_en = 1'b0; // RULE5
                next_q.se0_cnt = 8'h00;
            end
        end
        else
        begin
            next_q.se0_cnt = 8'h00;
        end
        if (q.sof_en && q.port_en && !q.bus_rst)
        begin
            next_q.frame_cnt = q.frame_cnt + 16'h0001;
            if (q.frame_cnt == 16'(FRAME_CYCLES - 1))
            begin
                next_q.frame_cnt = 16'h0000;
                next_q.sof_pulse = 1'b1; // RULE11
            end
        end
        else
        begin
            next_q.frame_cnt = 16'h0000;
        end
        if (rd_go)
        begin
            next_q.rvalid = 1'b1;
            next_q.rresp = uhe_pkg::RESP_OKAY;
            next_q.rdata = 32'h0000_0000;
            case (rd_idx)
                uhe_pkg::IDX_PORT:   next_q.rdata[7:0] = {q.pd_dis, 1'b0, q.dp_s2, q.dm_s2,
                                         1'b0, q.slow, q.bus_rst, q.port_en}; // RULE1 RULE2
                uhe_pkg::IDX_MODE:   next_q.rdata[7:0] = {1'b0, q.tx_en, 1'b0, q.tx_dbl,
                                         q.rx_en, 2'b00, q.rx_dbl};
                uhe_pkg::IDX_RXADDR: next_q.rdata[15:0] = q.rx_addr;
                uhe_pkg::IDX_TXADDR: next_q.rdata[15:0] = q.tx_addr;
                uhe_pkg::IDX_AUX:    next_q.rdata[7:0] = {q.pre, q.sof_en, 6'h00};
                uhe_pkg::IDX_TOKEN:  next_q.rdata[7:0] = q.token;
                uhe_pkg::IDX_RXCTRL: next_q.rdata[7:0] = {q.rx_tog, 2'b00, q.rx_auto,
                                         1'b0, q.rx_nohs, 2'b00};
                uhe_pkg::IDX_TXLEN:  next_q.rdata[7:0] = q.tx_len;
                uhe_pkg::IDX_TXCTRL: next_q.rdata[7:0] = {1'b0, q.tx_tog, 1'b0, q.tx_auto,
                                         3'b000, q.tx_nohs};
                uhe_pkg::IDX_STATUS: next_q.rdata[7:0] = {q.done, q.tog_ok, 2'b00, q.hs_pid};
                uhe_pkg::IDX_RXCNT:  next_q.rdata[7:0] = q.rx_count;
                default:             next_q.rresp = uhe_pkg::RESP_SLV;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '0;
            q.pd_dis <= 1'b1; // RULE23
            q.eng <= uhe_pkg::ENG_IDLE;
        end
        else
        begin
            q <= next_q;
        end
    end

    assign s_axi_bvalid           = q.bvalid;
    assign s_axi_bresp            = q.bresp;
    assign s_axi_rvalid           = q.rvalid;
    assign s_axi_rresp            = q.rresp;
    assign s_axi_rdata            = q.rdata;
    assign pulldown_enable        = !q.pd_dis;   // RULE23
    assign force_bus_reset        = q.bus_rst;   // RULE4
    assign root_port_enable       = q.port_en;
    assign port_slow_speed_select = q.slow;      // RULE3
    assign preamble_enable        = q.pre;       // RULE10
    assign frame_start_request    = q.sof_pulse;
    assign xact_start             = q.start;
    assign xact_token_pid         = q.token[7:4];
    assign xact_endpoint          = q.token[3:0];
    assign xact_data_pid          = q.data_pid;
    assign xact_buffer_address    = q.buf_addr;
    assign xact_length            = q.tx_len;    // RULE16
    assign xact_expect_handshake  = !q.tx_nohs;  // RULE19
    assign xact_send_ack          = !q.rx_nohs;  // RULE15

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence port_write(int unsigned bitpos, logic val);
        wr_go && wr_idx == uhe_pkg::IDX_PORT && s_axi_wstrb[0] && wb[bitpos] == val;
    endsequence

    dplus_read_a: assert property ($rose(s_axi_rvalid) && $past(rd_idx) == uhe_pkg::IDX_PORT
        |-> s_axi_rdata[uhe_pkg::PORT_DP] == $past(q.dp_s2)) else $error("d+ level misread"); // RULE1
    dminus_read_a: assert property (rd_go && rd_idx == uhe_pkg::IDX_PORT
        |=> s_axi_rdata[uhe_pkg::PORT_DM] == $past(q.dm_s2)) else $error("d- level misread"); // RULE2
    speed_write_a: assert property (wr_go && wr_idx == uhe_pkg::IDX_PORT && s_axi_wstrb[0]
        |=> port_slow_speed_select == $past(wb[uhe_pkg::PORT_SLOW])) else $error("speed wrong"); // RULE3
    bus_reset_end_a: assert property ($fell(force_bus_reset)
        |-> $past(wr_go && wr_idx == uhe_pkg::IDX_PORT)) else $error("reset ended alone"); // RULE4
    port_drop_a: assert property (root_port_enable && !force_bus_reset && !q.dp_s2
        && !q.dm_s2 && q.se0_cnt == 8'(uhe_pkg::DISC_CYC - 1) && !wr_go
        |=> !root_port_enable) else $error("disconnect missed"); // RULE5
    tx_gate_a: assert property (xact_start && xact_token_pid != uhe_pkg::PID_IN
        |-> $past(q.tx_en && q.port_en)) else $error("tx while disabled"); // RULE6
    launch_a: assert property (wr_go && wr_idx == uhe_pkg::IDX_TOKEN && s_axi_wstrb[0]
        && q.eng == uhe_pkg::ENG_IDLE
        |=> xact_start || (q.done && q.hs_pid == uhe_pkg::PID_NONE))
        else $error("launch lost"); // RULE24
    tx_buffer_a: assert property ($rose(q.start) && !q.is_in && $past(q.tx_dbl && q.tx_tog)
        |-> xact_buffer_address == $past(q.tx_addr[14:0]) + uhe_pkg::BUF_STEP)
        else $error("tx buffer wrong"); // RULE7
    rx_flip_a: assert property (xact_done && q.eng == uhe_pkg::ENG_BUSY && q.is_in && q.rx_auto
        && xact_rx_data_pid == (q.rx_tog ? uhe_pkg::PID_DATA1 : uhe_pkg::PID_DATA0)
        |=> q.rx_tog != $past(q.rx_tog) && q.tog_ok) else $error("rx toggle stuck"); // RULE14
    frame_gate_a: assert property (frame_start_request |-> $past(q.sof_en))
        else $error("frame start while off"); // RULE11
endmodule // uhe_host_ctrl
`default_nettype wire

// file: pkg/uhe_pkg.sv
// Purpose: shared constants and types of the usb host endpoint control block
// Assumes: 40 MHz system clock, registers reached over axi4-lite
// Notes:   register indices are word indices; byte address is four times the index
package uhe_pkg;
    localparam int unsigned CLK_MHZ   = 40;
    localparam int unsigned DISC_NS   = 2500;
    localparam int unsigned DISC_CYC  = (DISC_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned FRAME_US  = 1000;
    localparam int unsigned FRAME_CYC = FRAME_US * CLK_MHZ;

    localparam logic [5:0] IDX_PORT   = 6'h01;
    localparam logic [5:0] IDX_MODE   = 6'h0d;
    localparam logic [5:0] IDX_RXADDR = 6'h18;
    localparam logic [5:0] IDX_TXADDR = 6'h1c;
    localparam logic [5:0] IDX_AUX    = 6'h26;
    localparam logic [5:0] IDX_TOKEN  = 6'h28;
    localparam logic [5:0] IDX_RXCTRL = 6'h2a;
    localparam logic [5:0] IDX_TXLEN  = 6'h2c;
    localparam logic [5:0] IDX_TXCTRL = 6'h2e;
    localparam logic [5:0] IDX_STATUS = 6'h30;
    localparam logic [5:0] IDX_RXCNT  = 6'h31;

    localparam int unsigned PORT_PD_DIS = 7;
    localparam int unsigned PORT_DP     = 5;
    localparam int unsigned PORT_DM     = 4;
    localparam int unsigned PORT_SLOW   = 2;
    localparam int unsigned PORT_BUSRST = 1;
    localparam int unsigned PORT_EN     = 0;
    localparam int unsigned MODE_TX_EN  = 6;
    localparam int unsigned MODE_TX_DBL = 4;
    localparam int unsigned MODE_RX_EN  = 3;
    localparam int unsigned MODE_RX_DBL = 0;
    localparam int unsigned AUX_PRE     = 7;
    localparam int unsigned AUX_SOF     = 6;
    localparam int unsigned CTRL_RTOG   = 7;
    localparam int unsigned CTRL_TTOG   = 6;
    localparam int unsigned CTRL_AUTO   = 4;
    localparam int unsigned CTRL_RNOHS  = 2;
    localparam int unsigned CTRL_TNOHS  = 0;
    localparam int unsigned STAT_DONE   = 7;
    localparam int unsigned STAT_TOGOK  = 6;
    localparam int unsigned ADDR_BITS   = 15;

    localparam logic [14:0] BUF_STEP   = 15'h0040;
    localparam logic [3:0]  PID_OUT    = 4'h1;
    localparam logic [3:0]  PID_IN     = 4'h9;
    localparam logic [3:0]  PID_DATA0  = 4'h3;
    localparam logic [3:0]  PID_DATA1  = 4'hb;
    localparam logic [3:0]  PID_ACK    = 4'h2;
    localparam logic [3:0]  PID_NONE   = 4'h0;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLV   = 2'h2;

    typedef enum logic {ENG_IDLE, ENG_BUSY} uhe_eng_type;
endpackage

// file: verification/uhe_engine_model.sv
// Purpose: packet engine stand-in facing the host endpoint control block
// Assumes: same clock as the block; one launch at a time
// Notes:   answer delay is settable so prompt and slow replies both occur
`timescale 1ns/1ps
`default_nettype none
module uhe_engine_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       xact_start,
    input  wire logic [7:0] delay,
    input  wire logic [3:0] hs_pid,
    input  wire logic [3:0] rx_pid,
    input  wire logic [7:0] rx_count,
    output logic            xact_done,
    output logic [3:0]      xact_handshake_pid,
    output logic [3:0]      xact_rx_data_pid,
    output logic [7:0]      xact_rx_count
);
    logic       busy;
    logic [7:0] wait_cnt;

    // results are only valid in the done cycle; inverted elsewhere so stale use shows
    assign xact_handshake_pid = xact_done ? hs_pid : ~hs_pid;
    assign xact_rx_data_pid   = xact_done ? rx_pid : ~rx_pid;
    assign xact_rx_count      = xact_done ? rx_count : ~rx_count;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            busy      <= 1'b0;
            wait_cnt  <= 8'h00;
            xact_done <= 1'b0;
        end
        else
        begin
            xact_done <= 1'b0;
            if (xact_start)
            begin
                busy     <= 1'b1;
                wait_cnt <= delay;
            end
            else if (busy && wait_cnt == 8'h00)
            begin
                busy      <= 1'b0;
                xact_done <= 1'b1;
            end
            else if (busy)
                wait_cnt <= wait_cnt - 8'h01;
        end
    end
endmodule // uhe_engine_model
`default_nettype wire

// file: verification/tb_usb_host_endpoint_control.sv
// Purpose: self-checking bench for the usb host endpoint control block
// Assumes: frame count shortened to 50 cycles; engine model answers launches
// Notes:   registers reached only through the axi4-lite tasks below
`timescale 1ns/1ps
`default_nettype none
module tb_usb_host_endpoint_control;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        arvalid = 1'b0;
    logic        dp = 1'b1;
    logic        dm = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [7:0]  delay = 8'h00;
    logic [3:0]  hs_in = uhe_pkg::PID_ACK;
    logic [3:0]  rx_pid = uhe_pkg::PID_DATA1;
    logic [7:0]  rx_cnt = 8'h11;
    logic        awready, wready, bvalid, arready, rvalid, pd_en, bus_rst, port_en;
    logic        slow, pre_en, sof, x_start, x_hs_exp, x_ack, x_done;
    logic [1:0]  bresp, rresp, resp;
    logic [3:0]  t_pid, t_ep, d_pid, hs_pid, rxd_pid;
    logic [7:0]  x_len, rxd_cnt;
    logic [14:0] b_addr;
    logic [31:0] rdata, rd_data;
    logic [5:0]  zero_idx [5] = '{uhe_pkg::IDX_MODE, uhe_pkg::IDX_AUX, uhe_pkg::IDX_TOKEN,
                                  uhe_pkg::IDX_RXCTRL, uhe_pkg::IDX_TXCTRL};
    int          bad_count = 0;
    int          checks = 0;
    int          starts = 0;
    int          sofs = 0;
    int          n;

    uhe_host_ctrl #(.FRAME_CYCLES(50)) dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .dplus_line_level(dp), .dminus_line_level(dm), .pulldown_enable(pd_en),
        .force_bus_reset(bus_rst), .root_port_enable(port_en),
        .port_slow_speed_select(slow), .preamble_enable(pre_en),
        .frame_start_request(sof), .xact_start(x_start), .xact_token_pid(t_pid),
        .xact_endpoint(t_ep), .xact_data_pid(d_pid), .xact_buffer_address(b_addr),
        .xact_length(x_len), .xact_expect_handshake(x_hs_exp), .xact_send_ack(x_ack),
        .xact_done(x_done), .xact_handshake_pid(hs_pid), .xact_rx_data_pid(rxd_pid),
        .xact_rx_count(rxd_cnt));

    uhe_engine_model eng (
        .aclk(aclk), .aresetn(aresetn), .xact_start(x_start), .delay(delay),
        .hs_pid(hs_in), .rx_pid(rx_pid), .rx_count(rx_cnt), .xact_done(x_done),
        .xact_handshake_pid(hs_pid), .xact_rx_data_pid(rxd_pid), .xact_rx_count(rxd_cnt));

    initial
    begin
        forever #12.5 aclk = ~aclk;
    end

    always @(posedge aclk)
    begin
        if (x_start === 1'b1)
            starts++;
        if (sof === 1'b1)
            sofs++;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        awaddr <= {idx, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do @(posedge aclk); while (!(awready && wready));
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge aclk); while (!bvalid);
        resp = bresp;
    endtask

    task automatic rd(input logic [5:0] idx);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rd_data = rdata;
        resp = rresp;
    endtask

    // launch by token write, poll done, compare masked status, then clear it
    task automatic xact(input logic [7:0] tok, input logic [7:0] msk, input logic [7:0] st);
        wr(uhe_pkg::IDX_TOKEN, {24'h0, tok});
        chk(32'(resp), 32'(uhe_pkg::RESP_OKAY));
        do rd(uhe_pkg::IDX_STATUS); while (rd_data[7] !== 1'b1);
        chk(rd_data & {24'h0, msk}, {24'h0, st});
        wr(uhe_pkg::IDX_STATUS, 32'h0000_0080);
    endtask

    // sampled on falling edges so the pulse counter never races the window
    task automatic sof_window(input int exp);
        @(negedge aclk);
        n = sofs;
        repeat (100) @(negedge aclk);
        chk(32'(sofs - n), 32'(exp));
        @(posedge aclk);
    endtask

    initial
    begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        end_of_test();
    end

    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        // line levels need the two synchroniser stages before the first read
        repeat (3) @(posedge aclk);
        rd(uhe_pkg::IDX_PORT);
        chk(rd_data, 32'h0000_00a0);
        chk(32'(pd_en), 32'h0);
        foreach (zero_idx[i])
        begin
            rd(zero_idx[i]);
            chk(rd_data, 32'h0000_0000);
        end
        dp <= 1'b0;
        dm <= 1'b1;
        repeat (3) @(posedge aclk);
        rd(uhe_pkg::IDX_PORT);
        chk(rd_data, 32'h0000_0090);
        wr(uhe_pkg::IDX_PORT, 32'h0000_0007);
        chk(32'({pd_en, slow, bus_rst, port_en}), 32'hf);
        rd(uhe_pkg::IDX_PORT);
        chk(rd_data, 32'h0000_0017);
        wr(uhe_pkg::IDX_PORT, 32'h0000_0001);
        chk(32'({slow, bus_rst, port_en}), 32'h1);
        rd(6'h3f);
        chk({rd_data[29:0], resp}, {30'h0, uhe_pkg::RESP_SLV});
        wr(uhe_pkg::IDX_MODE, 32'h0000_0050);
        wr(uhe_pkg::IDX_TXADDR, 32'h0000_9234);
        wr(uhe_pkg::IDX_TXLEN, 32'h0000_002a);
        wr(uhe_pkg::IDX_TXCTRL, 32'h0000_0050);
        xact({uhe_pkg::PID_OUT, 4'h3}, 8'hbf, {4'h8, uhe_pkg::PID_ACK});
        chk(32'({t_pid, t_ep, x_len, d_pid, x_hs_exp}),
            32'({uhe_pkg::PID_OUT, 4'h3, 8'h2a, uhe_pkg::PID_DATA1, 1'b1}));
        chk(32'(b_addr), 32'(15'h1234 + uhe_pkg::BUF_STEP));
        rd(uhe_pkg::IDX_TXCTRL);
        chk(rd_data, 32'h0000_0010);
        wr(uhe_pkg::IDX_TXCTRL, 32'h0000_0001);
        hs_in <= uhe_pkg::PID_NONE;
        delay <= 8'd20;
        xact({uhe_pkg::PID_OUT, 4'h3}, 8'hbf, 8'h80);
        chk(32'({d_pid, x_hs_exp, b_addr}), 32'({uhe_pkg::PID_DATA0, 1'b0, 15'h1234}));
        rd(uhe_pkg::IDX_TXCTRL);
        chk(rd_data, 32'h0000_0001);
        wr(uhe_pkg::IDX_MODE, 32'h0000_0009);
        wr(uhe_pkg::IDX_RXADDR, 32'h0000_0400);
        wr(uhe_pkg::IDX_RXCTRL, 32'h0000_0090);
        hs_in <= uhe_pkg::PID_ACK;
        delay <= 8'd0;
        xact({uhe_pkg::PID_IN, 4'h5}, 8'hff, {4'hc, uhe_pkg::PID_ACK});
        chk(32'({x_ack, b_addr}), 32'({1'b1, 15'h0400 + uhe_pkg::BUF_STEP}));
        rd(uhe_pkg::IDX_RXCNT);
        chk(rd_data, 32'h0000_0011);
        rd(uhe_pkg::IDX_RXCTRL);
        chk(rd_data, 32'h0000_0010);
        wr(uhe_pkg::IDX_RXCTRL, 32'h0000_0014);
        xact({uhe_pkg::PID_IN, 4'h5}, 8'hff, {4'h8, uhe_pkg::PID_ACK});
        chk(32'({x_ack, b_addr}), 32'({1'b0, 15'h0400}));
        rd(uhe_pkg::IDX_RXCTRL);
        chk(rd_data, 32'h0000_0014);
        xact({uhe_pkg::PID_OUT, 4'h3}, 8'hbf, 8'h80);
        chk(32'(starts), 32'd4);
        wr(uhe_pkg::IDX_AUX, 32'h0000_00c0);
        chk(32'(pre_en), 32'h1);
        sof_window(2);
        wr(uhe_pkg::IDX_AUX, 32'h0000_0000);
        chk(32'(pre_en), 32'h0);
        sof_window(0);
        dm <= 1'b0;
        repeat (110) @(posedge aclk);
        rd(uhe_pkg::IDX_PORT);
        chk({rd_data[30:0], port_en}, 32'h0000_0000);
        end_of_test();
    end
endmodule // tb_usb_host_endpoint_control
`default_nettype wire
